// ### src/uds_pkg.sv
// Shared constants and carriers for the USB device state and interrupt block
package uds_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte offsets
  localparam logic [7:0] OFS_FRAME  = 8'h00;
  localparam logic [7:0] OFS_GLOBAL = 8'h04;
  localparam logic [7:0] OFS_FADDR  = 8'h08;
  localparam logic [7:0] OFS_IER    = 8'h10;
  localparam logic [7:0] OFS_IDR    = 8'h14;
  localparam logic [7:0] OFS_IMR    = 8'h18;
  localparam logic [7:0] OFS_ISR    = 8'h1C;
  localparam logic [7:0] OFS_ICR    = 8'h20;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int FRM_CNT_W    = 11;
  localparam int FRM_BAD_POS  = 16;
  localparam int FRM_GOOD_POS = 17;
  localparam int BYTE_GOOD_POS = 4;
  localparam int BYTE_BAD_POS  = 3;
  localparam int GLB_ADDR_POS = 0;
  localparam int GLB_CFG_POS  = 1;
  localparam int DEVICE_ADDRESS_VALUE_W       = 7;
  localparam int FEN_POS      = 8;
  localparam int IRQ_EP_POS   = 0;
  localparam int IRQ_SUSP_POS = 8;
  localparam int IRQ_RSM_POS  = 9;
  localparam int IRQ_SOF_POS  = 11;
  localparam int IRQ_BRST_POS = 12;
  localparam int IRQ_WAKE_POS = 13;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values and bit groups
  localparam logic [31:0] IRQ_STATUS_BITS = 32'h0000_3B0F;
  localparam logic [31:0] IRQ_MASK_BITS   = 32'h0000_2B0F;
  localparam logic [31:0] IRQ_FIXED_ON    = 32'h0000_1000;
  localparam logic [31:0] IMR_RST         = 32'h0000_0200;
  localparam logic [31:0] ISR_RST         = 32'h0000_0000;
  localparam logic [6:0]  DEVICE_ADDRESS_VALUE_RST        = 7'h00;
  localparam logic        FEN_RST         = 1'b1;

  // Bus handshake states
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_DONE = 2'b10
  } uds_bus_e;

  // Events from the packet engine, one-cycle pulses except ep_irq, sof_err and sof_frame
  typedef struct packed {
    logic        frame_packet_ident;
    logic        frame_packet_end;
    logic        sof_err;
    logic [10:0] sof_frame;
    logic [3:0]  ep_irq;
    logic        suspend;
    logic        resume;
    logic        wakeup;
    logic        bus_reset_done;
  } uds_link_s;

  // Device state towards the packet engine
  typedef struct packed {
    logic       address_state_bit;
    logic       configured_bit;
    logic [6:0] device_address_value;
    logic       function_enable_bit;
  } uds_dev_s;

endpackage

// ### src/uds_core.sv
// Frame tracking, device state, function address and interrupt mask/status
`timescale 1ns/1ps

// Notes on behaviour
// (R1) Keep 11-bit frame count, stored at end of each start-of-frame packet.
// (R2) Bad-frame flag set at packet end with error, cleared at next identifier.
// (R3) Good-frame flag set at clean packet end, cleared at next identifier.
// (R4) Frame-start interrupt status rises at the identifier, not at packet end.
// (R5) Byte view: good flag at high byte bit 4, bad at low byte bit 3.
// (R6) Address-state bit: write 1 sets it, write 0 ignored, reset clears.
// (R7) Firmware writes address first, sets address state after status stage.
// (R8) Configured bit reads state; write 1 enters, write 0 leaves.
// (R9) Firmware sets configured only when addressed and configuration succeeded.
// (R10) Seven-bit function address, zero after reset.
// (R11) Function-enable bit 8 reads back; 0 disables endpoints, 1 lets data flow.
// (R12) Firmware sets function enable after the host's bus reset.
// (R13) Enable register: 1 enables endpoint, suspend, resume, frame sources.
// (R14) Enable register bit 13 enables bus wakeup; 0 has no effect.
// (R15) Disable register: 1 disables the same sources, wakeup too.
// (R16) One readable mask, reset enabling resume and fixed bit 12.
// (R17) Mask bit 12, end of bus reset, always reads 1.
// (R18) Interrupt high while any status bit meets a set mask bit.
// (R19) Unused bits read zero, writes to them ignored.
module uds_core (
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                nrst,
  // Avalon-MM slave
  input  wire logic [7:0]          avs_address,
  input  wire logic                avs_read,
  input  wire logic                avs_write,
  input  wire logic [31:0]         avs_writedata,
  input  wire logic [3:0]          avs_byteenable,
  output logic      [31:0]         avs_readdata,
  output logic                     avs_waitrequest,
  // Packet engine side
  input  wire uds_pkg::uds_link_s  link_in,
  output uds_pkg::uds_dev_s        dev_state,
  // Byte-wide view of the frame status
  output logic      [7:0]          frame_byte_high,
  output logic      [7:0]          frame_byte_low,
  // Interrupt
  output logic                     irq
);

  ////////////////////////////////////////////////////////////////////////////
  // State
  uds_pkg::uds_bus_e bus_state;
  uds_pkg::uds_bus_e next_bus_state;

  logic [10:0] frame_count;
  logic        frame_good_flag;
  logic        frame_bad_flag;
  logic        address_state_bit;
  logic        configured_bit;
  logic [6:0]  device_address_value;
  logic        function_enable_bit;
  logic [31:0] irq_mask;
  logic [31:0] irq_status;

  ////////////////////////////////////////////////////////////////////////////
  // Bus handshake: one wait cycle, then the answer
  wire req = avs_read | avs_write;
  wire ack = (bus_state == uds_pkg::BUS_DONE);

  always_comb begin
    case (bus_state)
      uds_pkg::BUS_IDLE: next_bus_state = req ? uds_pkg::BUS_DONE : uds_pkg::BUS_IDLE;
      uds_pkg::BUS_DONE: next_bus_state = uds_pkg::BUS_IDLE;
      default:           next_bus_state = uds_pkg::BUS_IDLE;
    endcase
  end

  assign avs_waitrequest = req & ~ack;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      bus_state <= uds_pkg::BUS_IDLE;
    end else begin
      bus_state <= next_bus_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Decode; writes take effect on the edge that ends the access
  wire [31:0] lane_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                           {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  wire [31:0] wdata = avs_writedata & lane_mask;
  wire        wr    = avs_write & ack;

  wire sel_global = (avs_address == uds_pkg::OFS_GLOBAL);
  wire sel_faddr  = (avs_address == uds_pkg::OFS_FADDR);
  wire wr_global  = wr & sel_global;
  wire wr_faddr   = wr & sel_faddr;
  wire wr_ier     = wr & (avs_address == uds_pkg::OFS_IER);
  wire wr_idr     = wr & (avs_address == uds_pkg::OFS_IDR);
  wire wr_icr     = wr & (avs_address == uds_pkg::OFS_ICR);

  wire glb_addr_lane = avs_byteenable[0];
  wire device_address_value_lane     = avs_byteenable[0];
  wire fen_lane      = avs_byteenable[1];

  ////////////////////////////////////////////////////////////////////////////
  // Frame tracking
  // Packet end beats identifier in the same cycle so a flag is never lost
  wire [10:0] next_frame_count = link_in.frame_packet_end ? link_in.sof_frame : frame_count;
  wire next_frame_good = link_in.frame_packet_end ? ~link_in.sof_err :
                         (link_in.frame_packet_ident ? 1'b0 : frame_good_flag);
  wire next_frame_bad  = link_in.frame_packet_end ? link_in.sof_err :
                         (link_in.frame_packet_ident ? 1'b0 : frame_bad_flag);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      frame_count     <= 11'h000;
      frame_good_flag <= 1'b0;
      frame_bad_flag  <= 1'b0;
    end else begin
      frame_count     <= next_frame_count; // [R1]
      frame_good_flag <= next_frame_good;  // [R3]
      frame_bad_flag  <= next_frame_bad;   // [R2]
    end
  end

  // Literal byte layout; bit 3 of the low byte carries the bad flag
  assign frame_byte_high = {3'h0, frame_good_flag, 1'b0, frame_count[10:8]}; // [R5]
  assign frame_byte_low  = {frame_count[7:4], frame_bad_flag, frame_count[2:0]}; // [R5]

  ////////////////////////////////////////////////////////////////////////////
  // Device state
  // Address state can only be left through reset
  wire next_address_state = address_state_bit |
    (wr_global & glb_addr_lane & wdata[uds_pkg::GLB_ADDR_POS]); // [R6]
  wire next_configured = (wr_global & glb_addr_lane) ?
    wdata[uds_pkg::GLB_CFG_POS] : configured_bit; // [R8]
  wire [6:0] next_device_address = (wr_faddr & device_address_value_lane) ?
    wdata[uds_pkg::DEVICE_ADDRESS_VALUE_W-1:0] : device_address_value; // [R10]
  wire next_function_enable = (wr_faddr & fen_lane) ?
    wdata[uds_pkg::FEN_POS] : function_enable_bit; // [R11]

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      address_state_bit    <= 1'b0;
      configured_bit       <= 1'b0;
      device_address_value <= uds_pkg::DEVICE_ADDRESS_VALUE_RST;
      function_enable_bit  <= uds_pkg::FEN_RST;
    end else begin
      address_state_bit    <= next_address_state;
      configured_bit       <= next_configured;
      device_address_value <= next_device_address;
      function_enable_bit  <= next_function_enable;
    end
  end

  assign dev_state.address_state_bit    = address_state_bit;
  assign dev_state.configured_bit       = configured_bit;
  assign dev_state.device_address_value = device_address_value;
  assign dev_state.function_enable_bit  = function_enable_bit; // [R11]

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt mask: set and clear writes share one register
  wire [31:0] mask_set   = wr_ier ? (wdata & uds_pkg::IRQ_MASK_BITS) : 32'h0000_0000; // [R13] [R14]
  wire [31:0] mask_clr   = wr_idr ? (wdata & uds_pkg::IRQ_MASK_BITS) : 32'h0000_0000; // [R15]
  wire [31:0] next_mask  = (irq_mask | mask_set) & ~mask_clr; // [R16]
  wire [31:0] mask_view  = irq_mask | uds_pkg::IRQ_FIXED_ON;  // [R17]

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irq_mask <= uds_pkg::IMR_RST; // [R16]
    end else begin
      irq_mask <= next_mask;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt status: sticky events, write one to clear, set wins
  logic [31:0] evt;
  always_comb begin
    evt = 32'h0000_0000;
    evt[uds_pkg::IRQ_SUSP_POS] = link_in.suspend;
    evt[uds_pkg::IRQ_RSM_POS]  = link_in.resume;
    evt[uds_pkg::IRQ_SOF_POS]  = link_in.frame_packet_ident; // [R4]
    evt[uds_pkg::IRQ_BRST_POS] = link_in.bus_reset_done;
    evt[uds_pkg::IRQ_WAKE_POS] = link_in.wakeup;
  end

  wire [31:0] stat_clr   = wr_icr ? wdata : 32'h0000_0000;
  wire [31:0] next_status = ((irq_status & ~stat_clr) | evt) & uds_pkg::IRQ_STATUS_BITS;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irq_status <= uds_pkg::ISR_RST;
    end else begin
      irq_status <= next_status;
    end
  end

  // Endpoint status is owned by the endpoint logic and only mirrored here
  wire [31:0] status_view = irq_status |
    {28'h0000_000, link_in.ep_irq};

  // Level output, falls as soon as no masked pair is left
  assign irq = |(status_view & mask_view); // [R18]

  ////////////////////////////////////////////////////////////////////////////
  // Read data, captured in the wait cycle
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000; // [R19]
    case (avs_address)
      uds_pkg::OFS_FRAME: begin
        rd_mux[uds_pkg::FRM_CNT_W-1:0]   = frame_count;
        rd_mux[uds_pkg::FRM_BAD_POS]     = frame_bad_flag;
        rd_mux[uds_pkg::FRM_GOOD_POS]    = frame_good_flag;
      end
      uds_pkg::OFS_GLOBAL: begin
        rd_mux[uds_pkg::GLB_ADDR_POS] = address_state_bit;
        rd_mux[uds_pkg::GLB_CFG_POS]  = configured_bit;
      end
      uds_pkg::OFS_FADDR: begin
        rd_mux[uds_pkg::DEVICE_ADDRESS_VALUE_W-1:0] = device_address_value;
        rd_mux[uds_pkg::FEN_POS]    = function_enable_bit;
      end
      uds_pkg::OFS_IMR: rd_mux = mask_view;
      uds_pkg::OFS_ISR: rd_mux = status_view;
      default:          rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && !ack) begin
      avs_readdata <= rd_mux;
    end
  end

endmodule // uds_core

// ### testbench/uds_checker_asserts.sv
// Port assertions for the frame, device state and interrupt core
`timescale 1ns/1ps
module uds_checker (
  // Clock and reset
  input wire logic               clk,
  input wire logic               nrst,
  // Register bus
  input wire logic [7:0]         avs_address,
  input wire logic               avs_write,
  input wire logic [31:0]        avs_writedata,
  input wire logic [3:0]         avs_byteenable,
  input wire logic               avs_waitrequest,
  // Link events and state
  input wire uds_pkg::uds_link_s link_in,
  input wire uds_pkg::uds_dev_s  dev_state,
  input wire logic [7:0]         frame_byte_high,
  input wire logic [7:0]         frame_byte_low,
  input wire logic               irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  wire wr_done = avs_write && !avs_waitrequest;
  wire glb_wr  = wr_done && avs_address == uds_pkg::OFS_GLOBAL && avs_byteenable[0];
  wire fad_wr  = wr_done && avs_address == uds_pkg::OFS_FADDR;
  ////////////////////////////////////////////////////////////////////////////
  a_count_load: assert property (link_in.frame_packet_end |=>
    {frame_byte_high[2:0], frame_byte_low[7:4], frame_byte_low[2:0]} ==
    {$past(link_in.sof_frame[10:4]), $past(link_in.sof_frame[2:0])}) else $error("frame count not loaded");
  a_bad_set: assert property (link_in.frame_packet_end && link_in.sof_err |=>
    frame_byte_low[3] && !frame_byte_high[4]) else $error("bad flag wrong after packet end");
  a_good_set: assert property (link_in.frame_packet_end && !link_in.sof_err |=>
    frame_byte_high[4] && !frame_byte_low[3]) else $error("good flag wrong after packet end");
  a_ident_clear: assert property (link_in.frame_packet_ident && !link_in.frame_packet_end |=>
    !frame_byte_low[3] && !frame_byte_high[4]) else $error("flags not cleared by identifier");
  a_addr_hold: assert property (dev_state.address_state_bit |=>
    dev_state.address_state_bit) else $error("address state left without reset");
  a_addr_set: assert property (glb_wr && avs_writedata[0] |=>
    dev_state.address_state_bit) else $error("address state not entered");
  a_cfg_follow: assert property (glb_wr |=>
    dev_state.configured_bit == $past(avs_writedata[1])) else $error("configured bit not written");
  a_faddr_load: assert property (fad_wr && avs_byteenable[0] |=>
    dev_state.device_address_value == $past(avs_writedata[6:0])) else $error("address not written");
  a_enable_load: assert property (fad_wr && avs_byteenable[1] |=>
    dev_state.function_enable_bit == $past(avs_writedata[8])) else $error("enable not written");
  a_irq_cause: assert property ($rose(irq) |-> link_in.ep_irq != 4'h0 || $past(avs_write) ||
    $past(link_in.frame_packet_ident || link_in.suspend || link_in.resume || link_in.wakeup || link_in.bus_reset_done))
    else $error("interrupt rose without cause");
endmodule // uds_checker

// ### testbench/uds_host_model.sv
// Behavioural packet engine feeding frame and bus events
`timescale 1ns/1ps
module uds_host_model (
  // Clock
  input wire logic          clk,
  // Events towards the core
  output uds_pkg::uds_link_s link_in
);
  initial link_in = '0;
  // Frame word and error are inverted after the pulse, so a late sample shows
  task automatic fire(input logic pid, eop, err, input logic [10:0] frm, input logic [3:0] ep, bus);
    @(posedge clk);
    link_in.frame_packet_ident <= pid;
    link_in.frame_packet_end <= eop;
    link_in.sof_err <= err;
    link_in.sof_frame <= frm;
    link_in.ep_irq <= ep;
    {link_in.suspend, link_in.resume, link_in.wakeup, link_in.bus_reset_done} <= bus;
    @(posedge clk);
    link_in.frame_packet_ident <= 1'b0;
    link_in.frame_packet_end <= 1'b0;
    link_in.sof_err <= ~err;
    link_in.sof_frame <= ~frm;
    {link_in.suspend, link_in.resume, link_in.wakeup, link_in.bus_reset_done} <= 4'h0;
  endtask
endmodule // uds_host_model

// ### testbench/usb_device_state_and_irq_enable_tb_top.sv
// Register level bench for the USB device state and interrupt core
`timescale 1ns/1ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin bad_count++; $display("BAD %s exp %h got %h", n, e, g); end end
module usb_device_state_and_irq_enable_tb_top;
  logic               clk = 1'b0;
  logic               nrst = 1'b0;
  logic [7:0]         avs_address = 8'h00;
  logic               avs_read = 1'b0;
  logic               avs_write = 1'b0;
  logic [31:0]        avs_writedata = 32'h0000_0000;
  logic [3:0]         avs_byteenable = 4'hF;
  logic [31:0]        avs_readdata, rdata;
  logic               avs_waitrequest, irq;
  logic [7:0]         frame_byte_high, frame_byte_low;
  uds_pkg::uds_link_s link_in;
  uds_pkg::uds_dev_s  dev_state;
  int                 bad_count = 0, tests_run = 0, cycles = 0;
  always #2 clk = ~clk;
  uds_core dut_u (.clk, .nrst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
    .avs_waitrequest, .link_in, .dev_state, .frame_byte_high, .frame_byte_low, .irq);
  uds_host_model host_u (.clk, .link_in);
  task automatic summarize();
    if (bad_count == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Hang guard, far above the under two hundred cycles the sequence needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 6000) begin
      bad_count++;
      summarize();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Request held until the rising edge that sees waitrequest low; only the hang guard ends a wait
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do begin @(posedge clk); end while (avs_waitrequest !== 1'b0);
    rdata = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic chk_rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000);
    `CHK($sformatf("reg_%h", a), e, rdata)
  endtask
  task automatic chk_irq(input logic e);
    @(negedge clk);
    `CHK("irq", e, irq)
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    chk_rd(8'h00, 32'h0000_0000);
    chk_rd(8'h04, 32'h0000_0000);
    chk_rd(8'h08, 32'h0000_0100);
    chk_rd(8'h18, 32'h0000_1200);
    wr(8'h0C, 32'hFFFF_FFFF);
    chk_rd(8'h0C, 32'h0000_0000);
    // Address value first, address state afterwards
    wr(8'h08, 32'hFFFF_FF2A);
    chk_rd(8'h08, 32'h0000_012A);
    wr(8'h04, 32'hFFFF_FFFD);
    chk_rd(8'h04, 32'h0000_0001);
    wr(8'h04, 32'h0000_0002);
    chk_rd(8'h04, 32'h0000_0003);
    wr(8'h04, 32'h0000_0000);
    chk_rd(8'h04, 32'h0000_0001);
    wr(8'h08, 32'h0000_0055);
    @(negedge clk);
    `CHK("enable", 1'b0, dev_state.function_enable_bit)
    `CHK("address", 7'h55, dev_state.device_address_value)
    wr(8'h14, 32'hFFFF_FFFF);
    chk_rd(8'h18, 32'h0000_1000);
    wr(8'h10, 32'h0000_2000);
    chk_rd(8'h18, 32'h0000_3000);
    wr(8'h10, 32'h0000_0000);
    chk_rd(8'h18, 32'h0000_3000);
    wr(8'h10, 32'hFFFF_FFFF);
    chk_rd(8'h18, 32'h0000_3B0F);
    wr(8'h14, 32'h0000_0800);
    wr(8'h14, 32'h0000_0000);
    chk_rd(8'h18, 32'h0000_330F);
    host_u.fire(1'b0, 1'b0, 1'b0, 11'h000, 4'h5, 4'hF);
    chk_rd(8'h1C, 32'h0000_3305);
    chk_irq(1'b1);
    wr(8'h20, 32'hFFFF_FFFF);
    chk_rd(8'h1C, 32'h0000_0005);
    host_u.fire(1'b0, 1'b0, 1'b0, 11'h000, 4'h0, 4'h0);
    chk_irq(1'b0);
    wr(8'h08, 32'h0000_0100);
    chk_rd(8'h08, 32'h0000_0100);
    host_u.fire(1'b1, 1'b0, 1'b0, 11'h000, 4'h0, 4'h0);
    chk_rd(8'h1C, 32'h0000_0800);
    chk_irq(1'b0);
    host_u.fire(1'b0, 1'b1, 1'b0, 11'h5A5, 4'h0, 4'h0);
    chk_rd(8'h00, 32'h0002_05A5);
    `CHK("byte_high", 8'h15, frame_byte_high)
    `CHK("byte_low", 8'hA5, frame_byte_low)
    host_u.fire(1'b1, 1'b1, 1'b1, 11'h7FF, 4'h0, 4'h0);
    chk_rd(8'h00, 32'h0001_07FF);
    `CHK("byte_high", 8'h07, frame_byte_high)
    `CHK("byte_low", 8'hFF, frame_byte_low)
    host_u.fire(1'b1, 1'b0, 1'b0, 11'h123, 4'h0, 4'h0);
    chk_rd(8'h00, 32'h0000_07FF);
    wr(8'h10, 32'h0000_0800);
    chk_irq(1'b1);
    wr(8'h14, 32'h0000_0800);
    chk_irq(1'b0);
    wr(8'h10, 32'h0000_0800);
    wr(8'h20, 32'h0000_0800);
    chk_irq(1'b0);
    chk_rd(8'h1C, 32'h0000_0000);
    summarize();
  end
endmodule // usb_device_state_and_irq_enable_tb_top
bind uds_core uds_checker uds_checker_u (.clk, .nrst, .avs_address, .avs_write, .avs_writedata, .avs_byteenable,
  .avs_waitrequest, .link_in, .dev_state, .frame_byte_high, .frame_byte_low, .irq);
